// ===== design/tcse_channel_ctrl.sv
`timescale 1ns/1ps
module tcse_channel_ctrl
    import tcse_pkg::*;
#(
    parameter int NCH = NUM_CHAN,
    parameter int W   = WORD_W,
    parameter int DEP = ECHO_DEPTH
) (
    // clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rstn_i,
    // processor setting write port
    input  wire logic                  wr_en_i,
    input  wire logic [NCH-1:0]        wr_chan_i,   // one-hot, all = all
    input  wire logic [MODE_W-1:0]     wr_mode_i,
    input  wire logic                  wr_csrc_i,
    input  wire logic                  wr_pdn_i,
    input  wire logic [LOOP_W-1:0]     wr_loop_i,
    input  wire logic [NCH-1:0]        flag_clr_i,
    // polarity request per channel
    input  wire logic [NCH-1:0]        tx_pol_i,
    input  wire logic [NCH-1:0]        rx_pol_i,
    // transceiver clock outputs feeding the banks
    input  wire logic [NCH-1:0]        tx_out_clk_i,
    // per channel, per transceiver data
    input  wire logic [NCH*2*W-1:0]    rx_data_i,
    input  wire logic [NCH*2-1:0]      rx_valid_i,
    input  wire logic [NCH*2*W-1:0]    gen_data_i,
    // applied settings to transceivers (two per channel)
    output logic [NCH*2*MODE_W-1:0]    xcvr_mode_o,
    output logic [NCH*2-1:0]           xcvr_attr_reload_o,
    output logic [NCH*2-1:0]           xcvr_csrc_o,
    output logic [NCH*2-1:0]           xcvr_pdn_o,
    output logic [NCH*4-1:0]           xcvr_lb_o,
    output logic [NCH*2-1:0]           xcvr_tx_pol_o,
    output logic [NCH*2-1:0]           xcvr_rx_pol_o,
    output logic [NCH*2-1:0]           xcvr_tx_idle_o,
    output logic [NCH*2*W-1:0]         tx_data_o,
    // checker and analyzer tap
    output logic [NCH*2*W-1:0]         chk_data_o,
    output logic [NCH*2-1:0]           chk_valid_o,
    // bank user clock select and bank ok status
    output logic                       bot_usr_clk_o,
    output logic                       top_usr_clk_o,
    output logic                       bot_bank_ok_o,
    output logic                       top_bank_ok_o,
    // status
    output logic [NCH-1:0]             ovf_flag_o,
    output logic [NCH-1:0]             udf_flag_o
);

    ////////////////////////////////////////////////////////////////////
    // stored settings, one set per channel
    logic [MODE_W-1:0] mode_q [NCH];
    logic              csrc_q [NCH];
    logic              pdn_q  [NCH];
    tcse_loop_type     loop_q [NCH];
    logic [NCH-1:0]    reload_q;
    logic [NCH-1:0]    ovf_q;
    logic [NCH-1:0]    udf_q;
    logic [NCH-1:0]    echo_act;
    wire logic [NCH*2-1:0] lane_irdy;  // echo buffer can take a word
    wire logic [NCH*2-1:0] lane_ovld;  // echo buffer holds a word

    // map loopback code to transceiver select
    function automatic logic [1:0] xlb_of(input tcse_loop_type c);
        unique case (c)
            LB_INT_PAR:  xlb_of = XLB_PAR;
            LB_POST_SER: xlb_of = XLB_POST;
            LB_PRE_SER:  xlb_of = XLB_PRE;
            default:     xlb_of = XLB_OFF;   // none, echo, bad codes
        endcase
    endfunction : xlb_of

    // settings latch on the write cycle, seen one clock later
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int c = 0; c < NCH; c++) begin
                mode_q[c] <= MODE_RST;
                csrc_q[c] <= CSRC_RST;
                pdn_q[c]  <= PDN_RST;
                loop_q[c] <= LB_NONE;
            end
        end else if (wr_en_i) begin
            for (int c = 0; c < NCH; c++) begin
                if (wr_chan_i[c]) begin
                    mode_q[c] <= wr_mode_i;
                    csrc_q[c] <= wr_csrc_i;
                    pdn_q[c]  <= wr_pdn_i;
                    // out-of-range codes are ignored
                    if (wr_loop_i <= 3'(LB_ECHO)) begin
                        loop_q[c] <= tcse_loop_type'(wr_loop_i);
                    end
                end
            end
        end
    end

    // attribute reload strobe when the mode actually changes
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reload_q <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                reload_q[c] <= wr_en_i && wr_chan_i[c] &&
                               (wr_mode_i != mode_q[c]);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // fan each channel's settings to both transceivers
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            for (int x = 0; x < 2; x++) begin
                // one mode field width for all modes
                xcvr_mode_o[(c*2+x)*MODE_W +: MODE_W] = mode_q[c];
                xcvr_attr_reload_o[c*2+x] = reload_q[c];
                xcvr_csrc_o[c*2+x]  = csrc_q[c];
                xcvr_pdn_o[c*2+x]   = pdn_q[c];
                xcvr_lb_o[(c*2+x)*2 +: 2] = xlb_of(loop_q[c]);
                // parallel loopback ignores polarity
                xcvr_tx_pol_o[c*2+x] = (loop_q[c] != LB_INT_PAR) &&
                                       tx_pol_i[c];
                xcvr_rx_pol_o[c*2+x] = (loop_q[c] != LB_INT_PAR) &&
                                       rx_pol_i[c];
                // drivers held quiet in pre-driver loopback
                xcvr_tx_idle_o[c*2+x] = (loop_q[c] == LB_PRE_SER);
                // checker always sees the received stream
                chk_data_o[(c*2+x)*W +: W] = rx_data_i[(c*2+x)*W +: W];
                chk_valid_o[c*2+x] = rx_valid_i[c*2+x];
            end
            echo_act[c] = (loop_q[c] == LB_ECHO);
        end
    end

    // bank clocks from the clock-source channels
    assign bot_usr_clk_o = tx_out_clk_i[BOT_CLK_CHAN];
    assign top_usr_clk_o = tx_out_clk_i[TOP_CLK_CHAN];
    assign bot_bank_ok_o = !pdn_q[BOT_CLK_CHAN];
    assign top_bank_ok_o = !pdn_q[TOP_CLK_CHAN];

    ////////////////////////////////////////////////////////////////////
    // echo path: one buffer per transceiver, no clock compensation
    genvar g;
    generate
        for (g = 0; g < NCH*2; g++) begin : g_echo
            logic [W-1:0]  e_odat;
            logic [W-1:0]  tx_q;

            // buffer words that arrive while echo is on
            tcse_echo_fifo #(.WIDTH(W), .DEPTH(DEP)) u_fifo (
                .clk_i       (clk_i),
                .rstn_i      (rstn_i),
                .flush_i     (!echo_act[g/2]),
                .in_valid_i  (rx_valid_i[g]),
                .in_ready_o  (lane_irdy[g]),
                .in_data_i   (rx_data_i[g*W +: W]),
                .out_valid_o (lane_ovld[g]),
                .out_ready_i (1'b1),
                .out_data_o  (e_odat)
            );

            // transmit word from flops: echo or generator
            always_ff @(posedge clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    tx_q <= '0;
                end else if (echo_act[g/2]) begin
                    tx_q <= lane_ovld[g] ? e_odat : '0;
                end else begin
                    tx_q <= gen_data_i[g*W +: W];
                end
            end
            assign tx_data_o[g*W +: W] = tx_q;
        end
    endgenerate

    // lost words: full on write from either transceiver
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ovf_q <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                // set beats clear
                if (echo_act[c] &&
                    ((rx_valid_i[c*2] && !lane_irdy[c*2]) ||
                     (rx_valid_i[c*2+1] && !lane_irdy[c*2+1]))) begin
                    ovf_q[c] <= 1'b1;
                end else if (flag_clr_i[c]) begin
                    ovf_q[c] <= 1'b0;
                end
            end
        end
    end

    // underflow: echo on, slot due but buffer empty
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            udf_q <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (echo_act[c] && !rx_valid_i[c*2] &&
                    !lane_ovld[c*2]) begin
                    udf_q[c] <= 1'b1;
                end else if (flag_clr_i[c]) begin
                    udf_q[c] <= 1'b0;
                end
            end
        end
    end

    assign ovf_flag_o = ovf_q;
    assign udf_flag_o = udf_q;

    ////////////////////////////////////////////////////////////////////
    // checks
    property p_pre_idle;
        @(posedge clk_i) disable iff (!rstn_i)
        (loop_q[0] == LB_PRE_SER) |-> xcvr_tx_idle_o[1:0] == 2'b11;
    endproperty
    a_pre_idle: assert property (p_pre_idle)
        else $error("pre-driver loopback left tx active");

    property p_write_apply;
        @(posedge clk_i) disable iff (!rstn_i)
        (wr_en_i && wr_chan_i[0]) |=> xcvr_pdn_o[1:0] == {2{$past(wr_pdn_i)}};
    endproperty
    a_write_apply: assert property (p_write_apply)
        else $error("power setting not applied to both");

    property p_other_chan;
        @(posedge clk_i) disable iff (!rstn_i)
        (wr_en_i && !wr_chan_i[1]) |=> $stable(xcvr_csrc_o[3:2]);
    endproperty
    a_other_chan: assert property (p_other_chan)
        else $error("write leaked into other channel");

    property p_reload;
        @(posedge clk_i) disable iff (!rstn_i)
        (wr_en_i && wr_chan_i[0] && wr_mode_i != mode_q[0])
            |=> xcvr_attr_reload_o[0] ##1 (xcvr_attr_reload_o[0] ==
                $past(wr_en_i && wr_chan_i[0] && wr_mode_i != mode_q[0]));
    endproperty
    a_reload: assert property (p_reload)
        else $error("mode change did not reload attributes once");

    property p_par_pol;
        @(posedge clk_i) disable iff (!rstn_i)
        (loop_q[0] == LB_INT_PAR) |-> xcvr_tx_pol_o[1:0] == 2'b00;
    endproperty
    a_par_pol: assert property (p_par_pol)
        else $error("polarity active in parallel loopback");

    property p_sticky;
        @(posedge clk_i) disable iff (!rstn_i)
        !flag_clr_i[0] |=> ({ovf_q[0], udf_q[0]} &
            $past({ovf_q[0], udf_q[0]})) == $past({ovf_q[0], udf_q[0]});
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("sticky flag dropped without clear");

    property p_chk_tap;
        @(posedge clk_i) disable iff (!rstn_i)
        echo_act[0] |-> chk_valid_o[0] == rx_valid_i[0];
    endproperty
    a_chk_tap: assert property (p_chk_tap)
        else $error("checker lost data during echo");

    property p_bank_ok;
        @(posedge clk_i) disable iff (!rstn_i)
        pdn_q[BOT_CLK_CHAN] |-> !bot_bank_ok_o;
    endproperty
    a_bank_ok: assert property (p_bank_ok)
        else $error("bottom bank ok with clock channel down");

endmodule : tcse_channel_ctrl

// ===== design/tcse_echo_fifo.sv
`timescale 1ns/1ps
module tcse_echo_fifo
    import tcse_pkg::*;
#(
    parameter int WIDTH = WORD_W,
    parameter int DEPTH = ECHO_DEPTH
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rstn_i,
    input  wire logic             flush_i,
    // fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];   // flip-flop storage
    logic [AW-1:0]    wp_q;            // write index
    logic [AW-1:0]    rp_q;            // read index
    logic [AW:0]      cnt_q;           // words held
    logic             push;
    logic             pop;

    ////////////////////////////////////////////////////////////////////
    // handshake
    // full refuses the word even if a drain is due: keeps push simple
    assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    assign out_data_o  = mem_q[rp_q];

    // storage write, no reset needed for data
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wp_q] <= in_data_i;
        end
    end

    // pointers and fill count
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else if (flush_i) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + AW'(1);
            end
            if (pop) begin
                rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + AW'(1);
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule : tcse_echo_fifo

// ===== design/tcse_pkg.sv
package tcse_pkg;

    // channel and transceiver counts, word width and echo buffer depth
    localparam int NUM_CHAN       = 2;
    localparam int XCVR_PER_CHAN  = 2;
    localparam int WORD_W         = 20;
    localparam int ECHO_DEPTH     = 16;

    // banks: bottom bank clocked from channel 0, top bank from channel 1
    localparam int BOT_CLK_CHAN   = 0;
    localparam int TOP_CLK_CHAN   = 1;

    // field widths
    localparam int MODE_W         = 2;
    localparam int LOOP_W         = 3;

    // reset values of the per-channel settings
    localparam logic [1:0] MODE_RST  = 2'h0;
    localparam logic       CSRC_RST  = 1'h0; // 0 bank ref, 1 general ref
    localparam logic       PDN_RST   = 1'h0;

    // loopback codes
    typedef enum logic [2:0] {
        LB_NONE     = 3'b000,
        LB_INT_PAR  = 3'b001,
        LB_POST_SER = 3'b010,
        LB_PRE_SER  = 3'b011,
        LB_ECHO     = 3'b100
    } tcse_loop_type;

    // hardware loopback select to the transceiver
    localparam logic [1:0] XLB_OFF    = 2'h0;
    localparam logic [1:0] XLB_PAR    = 2'h1;
    localparam logic [1:0] XLB_POST   = 2'h2;
    localparam logic [1:0] XLB_PRE    = 2'h3;

    // attribute reload pulse length in clocks
    localparam logic [1:0] RELOAD_LEN = 2'h1;

endpackage : tcse_pkg

// ===== dv/tb.sv
`timescale 1ns/1ps
module tb;
    import tcse_pkg::*;
    localparam int L = NUM_CHAN*2; // lanes
    logic clk_i, rstn_i, wr_en_i, wr_csrc_i, wr_pdn_i, slow;
    logic [1:0] wr_chan_i, wr_mode_i, flag_clr_i, tx_pol_i, rx_pol_i;
    logic [1:0] tx_out_clk_i, ovf, udf;
    logic bok, tok, buc, tuc;
    logic [2:0] wr_loop_i;
    logic [L*WORD_W-1:0] rxd, gen, txd, chd;
    logic [L-1:0] rxv, chv, rel, csrc, pdn, serial_tx_positive, rxp, idle;
    logic [L*2-1:0] mode;
    logic [L*2-1:0] lb;
    logic [WORD_W-1:0] t0, t1;
    int miscompares, check_count;
    logic [31:0] rs;                    // random state
    logic [1:0] e_mode [2];             // expected settings
    logic e_csrc [2], e_pdn [2], e_rel [2];
    logic [2:0] e_loop [2];

    ////////////////////////////////////////////////////////////////////////
    // clock, partner, blocks under test
    initial begin
        clk_i = 0;
        forever #5 clk_i = !clk_i;
    end
    tcse_remote_model i_rem (.clk_i(clk_i), .rstn_i(rstn_i),
        .slow_i(slow), .rx_data_o(rxd), .rx_valid_o(rxv));
    tcse_channel_ctrl i_dut (.clk_i(clk_i), .rstn_i(rstn_i),
        .wr_en_i(wr_en_i), .wr_chan_i(wr_chan_i), .wr_mode_i(wr_mode_i),
        .wr_csrc_i(wr_csrc_i), .wr_pdn_i(wr_pdn_i), .wr_loop_i(wr_loop_i),
        .flag_clr_i(flag_clr_i), .tx_pol_i(tx_pol_i), .rx_pol_i(rx_pol_i),
        .tx_out_clk_i(tx_out_clk_i), .rx_data_i(rxd), .rx_valid_i(rxv),
        .gen_data_i(gen), .xcvr_mode_o(mode), .xcvr_attr_reload_o(rel),
        .xcvr_csrc_o(csrc), .xcvr_pdn_o(pdn), .xcvr_lb_o(lb),
        .xcvr_tx_pol_o(serial_tx_positive), .xcvr_rx_pol_o(rxp), .xcvr_tx_idle_o(idle),
        .tx_data_o(txd), .chk_data_o(chd), .chk_valid_o(chv),
        .bot_usr_clk_o(buc), .top_usr_clk_o(tuc), .bot_bank_ok_o(bok),
        .top_bank_ok_o(tok), .ovf_flag_o(ovf), .udf_flag_o(udf));

    ////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [1:0] lb_of(input logic [2:0] c);
        case (c)
            LB_INT_PAR:  return XLB_PAR;
            LB_POST_SER: return XLB_POST;
            LB_PRE_SER:  return XLB_PRE;
            default:     return XLB_OFF; // none and echo
        endcase
    endfunction : lb_of
    task automatic chk(input string nm, input logic [31:0] e, s);
        check_count++;
        if (e !== s) begin
            miscompares++;
            $display("[ERR] %s exp %h got %h", nm, e, s);
        end
    endtask : chk
    task automatic stop_test();
        $display("checks %0d errors %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : stop_test
    // one write; caller lowers wr_en_i, so writes may run back to back
    task automatic wr(input logic [1:0] m, md, input logic cs, pd,
                      input logic [2:0] lp);
        wr_en_i <= 1;
        wr_chan_i <= m;
        wr_mode_i <= md;
        wr_csrc_i <= cs;
        wr_pdn_i <= pd;
        wr_loop_i <= lp;
        @(posedge clk_i);
        for (int c = 0; c < 2; c++) begin
            e_rel[c] = m[c] && (md != e_mode[c]);
            if (m[c]) begin
                e_mode[c] = md;
                e_csrc[c] = cs;
                e_pdn[c] = pd;
                if (lp <= 3'h4) e_loop[c] = lp; // code above 4 refused
            end
        end
    endtask : wr
    // compare the applied settings at mid-cycle, idle only on powered-up channels
    task automatic check_all(input logic r);
        @(negedge clk_i);
        for (int l = 0; l < L; l++) begin
            chk("mode", e_mode[l/2], mode[l*2 +: 2]);
            chk("reload", r & e_rel[l/2], rel[l]);
            chk("csrc", e_csrc[l/2], csrc[l]);
            chk("pdn", e_pdn[l/2], pdn[l]);
            chk("lb", lb_of(e_loop[l/2]), lb[l*2 +: 2]);
            chk("txpol", (e_loop[l/2] != LB_INT_PAR) & tx_pol_i[l/2],
                serial_tx_positive[l]);
            chk("rxpol", (e_loop[l/2] != LB_INT_PAR) & rx_pol_i[l/2],
                rxp[l]);
            if (!e_pdn[l/2])
                chk("idle", e_loop[l/2] == LB_PRE_SER, idle[l]);
            chk("tap", rxd[l*WORD_W +: WORD_W],
                chd[l*WORD_W +: WORD_W]);
            chk("tapv", rxv[l], chv[l]);
        end
        chk("bank", {!e_pdn[1], !e_pdn[0]}, {tok, bok});
        chk("uclk", tx_out_clk_i, {tuc, buc});
        @(posedge clk_i);
    endtask : check_all

    ////////////////////////////////////////////////////////////////////////
    // watchdog, far beyond the few hundred cycles the run needs
    initial begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        stop_test();
    end

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {rstn_i, wr_en_i, wr_csrc_i, wr_pdn_i, slow} = 0;
        {wr_chan_i, wr_mode_i, flag_clr_i, tx_pol_i, rx_pol_i} = 0;
        {tx_out_clk_i, wr_loop_i} = 0;
        gen = {L{20'h5a5a5}};
        rs = 32'hd5cf;
        for (int c = 0; c < 2; c++) begin
            {e_mode[c], e_csrc[c], e_pdn[c], e_rel[c], e_loop[c]} = 0;
        end
        repeat (20) @(posedge clk_i);
        rstn_i <= 1;
        @(posedge clk_i);
        check_all(0);
        // random settings, refused codes and mask patterns among them
        for (int i = 0; i < 30; i++) begin
            rs = lfsr(rs);
            {rx_pol_i, tx_pol_i, tx_out_clk_i} <= rs[5:0];
            wr(rs[7:6] == 0 ? 2'h3 : rs[7:6], rs[9:8], rs[10], rs[11],
               rs[14:12] % 3'h6);
            if (rs[15]) wr(2'h1, rs[17:16], 0, 0, 3'h0); // back to back
            wr_en_i <= 0;
            check_all(1);
            check_all(0);
        end
        // every loopback code on channel 1, polarity requested
        {tx_pol_i, rx_pol_i} <= 4'hf;
        for (int c = 0; c < 6; c++) begin
            wr(2'h2, 2'h1, 1, 0, c[2:0]);
            wr_en_i <= 0;
            check_all(1);
        end
        // normal path, flags cleared
        wr(2'h3, 2'h0, 0, 0, LB_NONE);
        wr_en_i <= 0;
        flag_clr_i <= 2'h3;
        @(posedge clk_i);
        flag_clr_i <= 2'h0;
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        chk("flags", 4'h0, {ovf, udf});
        chk("gen", gen[19:0], txd[19:0]);
        // echo on channel 0 only
        wr(2'h1, 2'h0, 0, 0, LB_ECHO);
        wr_en_i <= 0;
        repeat (8) @(posedge clk_i);
        @(negedge clk_i);
        t0 = txd[19:0];
        @(negedge clk_i);
        t1 = txd[19:0];
        chk("echo", {t0[19:4] + 16'h1, 4'h0}, t1);
        chk("other", gen[59:40], txd[59:40]);
        chk("udf", 1'b0, udf[0]);
        slow <= 1;
        repeat (6) @(posedge clk_i);
        @(negedge clk_i);
        chk("udf", 1'b1, udf[0]);
        @(posedge clk_i);
        wr(2'h1, 2'h0, 0, 0, LB_NONE);
        wr_en_i <= 0;
        slow <= 0;
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        chk("sticky", 1'b1, udf[0]);
        @(posedge clk_i);
        flag_clr_i <= 2'h1;
        @(posedge clk_i);
        flag_clr_i <= 2'h0;
        @(negedge clk_i);
        chk("clr", 2'h0, udf);
        // echo on channel 1: each word goes back two clocks after arrival
        @(posedge clk_i);
        wr(2'h2, 2'h0, 0, 0, LB_ECHO);
        wr_en_i <= 0;
        for (int i = 0; i < 20; i++) begin
            @(negedge clk_i);
            if (i >= 2) begin
                chk("drain", t0, txd[59:40]);
            end
            t0 = t1;
            t1 = rxd[59:40];
        end
        // locked partner: nothing lost, paired lane echoes its own words
        chk("fill", 2'h0, {ovf[1], udf[1]});
        chk("drained", {t0[19:4] - 16'h1, 4'h3}, txd[79:60]);
        stop_test();
    end
endmodule : tb

// ===== dv/tcse_remote_model.sv
`timescale 1ns/1ps
// far-end tester; shares the local clock, so it is frequency locked
module tcse_remote_model
    import tcse_pkg::*;
(
    // clock and reset
    input  wire logic                          clk_i,
    input  wire logic                          rstn_i,
    // stall: one word every fourth cycle
    input  wire logic                          slow_i,
    // received words, lane index ch*2+x
    output logic [NUM_CHAN*2*WORD_W-1:0]       rx_data_o,
    output logic [NUM_CHAN*2-1:0]              rx_valid_o
);
    logic [15:0] cnt_q; // word counter
    logic [1:0]  ph_q;  // slow-mode phase
    logic        vld;   // word offered this cycle

    ////////////////////////////////////////////////////////////////////////
    // pacing; same clock as the local side
    // gaps of three cycles drain the echo buffer dry between words
    assign vld = rstn_i && (!slow_i || ph_q == 2'h0);
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_q <= 16'h0;
            ph_q  <= 2'h0;
        end else begin
            ph_q <= ph_q + 2'h1;
            if (vld) begin
                cnt_q <= cnt_q + 16'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // idle lanes carry the inverse word, never a stale copy
    always_comb begin
        for (int l = 0; l < NUM_CHAN*2; l++) begin
            rx_valid_o[l] = vld;
            rx_data_o[l*WORD_W +: WORD_W] = vld ? {cnt_q, 4'(l)}
                                                : ~{cnt_q, 4'(l)};
        end
    end
endmodule : tcse_remote_model
